// ===== logic/adcr_regs.sv
// Antenna driver conductance register bank and output stage code selection.
//
// Behaviour
// - N-driver register at 27h, reset 88h; carrier code 7:4, modulation 3:0.
// - Carrier n code reaches the stage only while a driver is on.
// - Modulation n code reaches the stage only while a driver is on.
// - Soft power-down forces the top bit of every field to one.
// - Every field is a binary-weighted code, passed through unchanged; the code sets the top bit during soft power-down.
// - Carrier p register at 28h, reset 20h, field 5:0, 7:6 reserved.
// - P stage uses carrier p code whenever no modulation is sent.
// - Modulation p register at 29h, reset 20h, field 5:0, 7:6 reserved.
// - P stage uses modulation p code during modulation periods.
// - Forced full ASK makes the modulation p code have no effect.
`timescale 1ns/1ps
`default_nettype none
module adcr_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic antenna_driver_one_on_in,
    input wire logic antenna_driver_two_on_in,
    input wire logic modulation_active_in,
    input wire logic forced_full_ask_in,
    input wire logic soft_power_down_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rdata_valid_out,
    output logic driver_active_out,
    output adcr_pkg::adcr_drive_t drive_out
);
    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // The map ends at 29h, so at least six address bits are needed.
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr_w
        $error("ADDR_W must lie between 6 and 8.");
    end

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;

    // Assertion is immediate, release is two clocks late and glitch free.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Forces the top bit of an n field during soft power-down.
    function automatic logic [3:0] force_n(input logic [3:0] v,
                                           input logic spd);
        force_n = v | {spd, 3'h0};
    endfunction

    // Forces the top bit of a p field during soft power-down.
    function automatic logic [5:0] force_p(input logic [5:0] v,
                                           input logic spd);
        force_p = v | {spd, 5'h00};
    endfunction

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    adcr_pkg::adcr_req_t req;
    logic [7:0] n_drv_q;
    logic [7:0] n_drv_d;
    logic [5:0] p_car_q;
    logic [5:0] p_car_d;
    logic [5:0] p_mod_q;
    logic [5:0] p_mod_d;

    // Request bundle; the address is zero-extended to the map width.
    always_comb begin
        req.wr_en = reg_wr_en_in;
        req.rd_en = reg_rd_en_in;
        req.addr = 8'h00;
        req.addr[ADDR_W-1:0] = reg_addr_in;
        req.wdata = reg_wdata_in;
    end

    // Write decode; the stored value is what the host wrote, the power-down
    // force is applied on the way out so it vanishes when power returns.
    always_comb begin
        n_drv_d = n_drv_q;
        p_car_d = p_car_q;
        p_mod_d = p_mod_q;
        if (req.wr_en && req.addr == adcr_pkg::ADCR_N_DRV_OFFS) begin
            n_drv_d = req.wdata;
        end else if (req.wr_en && req.addr == adcr_pkg::ADCR_P_CAR_OFFS) begin
            p_car_d = req.wdata[5:0];
        end else if (req.wr_en && req.addr == adcr_pkg::ADCR_P_MOD_OFFS) begin
            p_mod_d = req.wdata[5:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            n_drv_q <= adcr_pkg::ADCR_N_DRV_RST;
            p_car_q <= adcr_pkg::ADCR_P_CAR_RST;
            p_mod_q <= adcr_pkg::ADCR_P_MOD_RST;
        end else begin
            n_drv_q <= n_drv_d;
            p_car_q <= p_car_d;
            p_mod_q <= p_mod_d;
        end
    end

    // ------------------------------------------------------------------
    // Effective field values
    // ------------------------------------------------------------------
    logic [3:0] n_carrier_level;
    logic [3:0] n_modulation_level;
    logic [5:0] p_carrier_level;
    logic [5:0] p_modulation_level;

    // Readback and drivers both see the forced values, so software can
    // observe what the output stage really receives.
    always_comb begin
        n_carrier_level = force_n(
            n_drv_q[adcr_pkg::ADCR_N_CAR_LSB +: adcr_pkg::ADCR_N_FLD_W],
            soft_power_down_in);
        n_modulation_level = force_n(
            n_drv_q[adcr_pkg::ADCR_N_MOD_LSB +: adcr_pkg::ADCR_N_FLD_W],
            soft_power_down_in);
        p_carrier_level = force_p(p_car_q, soft_power_down_in);
        p_modulation_level = force_p(p_mod_q, soft_power_down_in);
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    // Unmapped offsets read as zero; data stands until the next read.
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = req.rd_en;
        if (req.rd_en) begin
            if (req.addr == adcr_pkg::ADCR_N_DRV_OFFS) begin
                rdata_d = {n_carrier_level, n_modulation_level};
            end else if (req.addr == adcr_pkg::ADCR_P_CAR_OFFS) begin
                rdata_d = {2'h0, p_carrier_level};
            end else if (req.addr == adcr_pkg::ADCR_P_MOD_OFFS) begin
                rdata_d = {2'h0, p_modulation_level};
            end else begin
                rdata_d = adcr_pkg::ADCR_RDATA_RST;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q <= adcr_pkg::ADCR_RDATA_RST;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------------
    // Output stage code selection
    // ------------------------------------------------------------------
    adcr_pkg::adcr_drive_t drive_q;
    adcr_pkg::adcr_drive_t drive_d;
    logic drv_on_q;
    logic drv_on_d;

    // Codes are binary weighted and passed through untouched; the analog
    // stage sums the weighted legs, so no decoding happens here.
    always_comb begin
        drv_on_d = antenna_driver_one_on_in | antenna_driver_two_on_in;
        drive_d.n_level = 4'h0;
        if (drv_on_d) begin
            if (modulation_active_in) begin
                drive_d.n_level = n_modulation_level;
            end else begin
                drive_d.n_level = n_carrier_level;
            end
        end
        if (!modulation_active_in) begin
            drive_d.p_level = p_carrier_level;
        end else if (forced_full_ask_in) begin
            // Full ASK switches the p stage off, so the code is unused.
            drive_d.p_level = 6'h00;
        end else begin
            drive_d.p_level = p_modulation_level;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            drive_q <= '0;
            drv_on_q <= 1'b0;
        end else begin
            drive_q <= drive_d;
            drv_on_q <= drv_on_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_rdata_valid_out = rvalid_q;
    assign drive_out = drive_q;
    assign driver_active_out = drv_on_q;
endmodule
`default_nettype wire

// ===== common/adcr_pkg.sv
// Package with register map, reset values and carriers of the conductance bank.
`default_nettype none
package adcr_pkg;
    // ------------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ADCR_N_DRV_OFFS = 8'h27;
    localparam logic [7:0] ADCR_P_CAR_OFFS = 8'h28;
    localparam logic [7:0] ADCR_P_MOD_OFFS = 8'h29;
    localparam logic [7:0] ADCR_N_DRV_RST = 8'h88;
    localparam logic [5:0] ADCR_P_CAR_RST = 6'h20;
    localparam logic [5:0] ADCR_P_MOD_RST = 6'h20;
    localparam logic [7:0] ADCR_RDATA_RST = 8'h00;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int ADCR_N_CAR_LSB = 4;
    localparam int ADCR_N_MOD_LSB = 0;
    localparam int ADCR_N_FLD_W = 4;
    localparam int ADCR_P_FLD_W = 6;

    // Register write/read request from the host interface.
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adcr_req_t;

    // Conductance codes presented to the antenna output stages.
    typedef struct packed {
        logic [3:0] n_level;
        logic [5:0] p_level;
    } adcr_drive_t;
endpackage
`default_nettype wire

// ===== verif/adcr_regs_props.sv
// Port checker for the antenna driver conductance bank.
`timescale 1ns/1ps
`default_nettype none
module adcr_regs_props (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic reg_rd_en_in,
    input wire logic antenna_driver_one_on_in,
    input wire logic antenna_driver_two_on_in,
    input wire logic modulation_active_in,
    input wire logic forced_full_ask_in,
    input wire logic soft_power_down_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rdata_valid_out,
    input wire logic driver_active_out,
    input wire adcr_pkg::adcr_drive_t drive_out
);
    // Short names keep each property on one line.
    wire logic on_w = antenna_driver_one_on_in | antenna_driver_two_on_in;
    wire logic mf_w = modulation_active_in & forced_full_ask_in;
    wire logic ask_w = mf_w & !soft_power_down_in;
    wire logic pdn_w = soft_power_down_in & on_w;
    wire logic pdp_w = soft_power_down_in & !mf_w;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_read_answer: assert property (
        reg_rd_en_in |=> reg_rdata_valid_out) else $error("no valid");
    a_valid_cause: assert property (
        reg_rdata_valid_out |-> $past(reg_rd_en_in)) else $error("stray valid");
    a_rdata_hold: assert property (
        !$past(reg_rd_en_in) |-> $stable(reg_rdata_out)) else $error("rdata");
    a_active_or: assert property (
        driver_active_out == $past(on_w)) else $error("driver active");
    a_n_off_zero: assert property (
        !$past(on_w) |-> drive_out.n_level == 4'h0) else $error("n not off");
    a_full_ask: assert property (
        $past(ask_w) |-> drive_out.p_level == 6'h00) else $error("p not 0");
    a_pd_n_msb: assert property (
        $past(pdn_w) |-> drive_out.n_level[3]) else $error("n msb low");
    a_pd_p_msb: assert property (
        $past(pdp_w) |-> drive_out.p_level[5]) else $error("p msb low");
endmodule
`default_nettype wire

// ===== verif/adcr_host_model.sv
// Host model that issues single-byte register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module adcr_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic valid_in,
    output logic wr_en_out = 1'b0,
    output logic rd_en_out = 1'b0,
    output logic [7:0] addr_out = 8'h00,
    output logic [7:0] wdata_out = 8'h00
);
    // One strobe cycle; released address and data lines get inverted so stale data shows.
    // The answer is due right after the strobe edge, so it is taken there
    // without waiting: a late or missing answer shows in the caller's check.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic v);
        @(posedge clk_in);
        #1;
        wr_en_out = w;
        rd_en_out = !w;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
        v = valid_in;
        q = rdata_in;
    endtask
endmodule
`default_nettype wire

// ===== verif/test_adcr_regs.sv
// Self-checking bench for the antenna driver conductance bank.
`timescale 1ns/1ps
`default_nettype none
module test_adcr_regs;
    logic clk = 1'b0, rst_n = 1'b0, one = 1'b0, two = 1'b0;
    logic modu = 1'b0, ffa = 1'b0, spd = 1'b0;
    logic wr, rd, valid, act;
    logic [7:0] addr, wdata, rdata, q;
    logic v;
    adcr_pkg::adcr_drive_t drv;
    int n_fail = 0;
    int checks_done = 0;
    adcr_regs adcr_regs_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
        .reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .antenna_driver_one_on_in(one),
        .antenna_driver_two_on_in(two), .modulation_active_in(modu),
        .forced_full_ask_in(ffa), .soft_power_down_in(spd),
        .reg_rdata_out(rdata), .reg_rdata_valid_out(valid),
        .driver_active_out(act), .drive_out(drv));
    adcr_host_model host_inst (.clk_in(clk), .rdata_in(rdata),
        .valid_in(valid), .wr_en_out(wr), .rd_en_out(rd),
        .addr_out(addr), .wdata_out(wdata));
    // Clock at 200 MHz.
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host_inst.xfer(1'b0, a, 8'h00, q, v);
        chk({9'h000, v}, 10'h001);
        chk({2'h0, q}, {2'h0, e});
    endtask
    // A write must not raise the read answer flag.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        host_inst.xfer(1'b1, a, d, q, v);
        chk({9'h000, v}, 10'h000);
    endtask
    // Register writes need two edges to reach the stage codes.
    task automatic cd(input adcr_pkg::adcr_drive_t e);
        repeat (3) @(posedge clk);
        #1;
        chk(drv, e);
        chk({9'h000, act}, {9'h000, one | two});
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog far beyond the expected run of about 64 cycles.
    initial begin
        #20000;
        n_fail++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        rc(8'h27, 8'h88);
        rc(8'h28, 8'h20);
        rc(8'h29, 8'h20);
        rc(8'h2a, 8'h00);
        wr_reg(8'h27, 8'ha5);
        wr_reg(8'h28, 8'hff);
        wr_reg(8'h29, 8'hd6);
        wr_reg(8'h2a, 8'h3c);
        rc(8'h27, 8'ha5);
        rc(8'h28, 8'h3f);
        rc(8'h29, 8'h16);
        $display("test access done");
        one = 1'b1;
        cd({4'ha, 6'h3f});
        modu = 1'b1;
        cd({4'h5, 6'h16});
        ffa = 1'b1;
        cd({4'h5, 6'h00});
        {one, two, modu} = 3'b010;
        cd({4'ha, 6'h3f});
        {two, modu, ffa} = 3'b010;
        cd({4'h0, 6'h16});
        $display("test drive done");
        wr_reg(8'h27, 8'h12);
        wr_reg(8'h28, 8'h05);
        wr_reg(8'h29, 8'h07);
        {spd, two, modu} = 3'b110;
        cd({4'h9, 6'h25});
        modu = 1'b1;
        cd({4'ha, 6'h27});
        rc(8'h27, 8'h9a);
        spd = 1'b0;
        rc(8'h28, 8'h05);
        $display("test powerdown done");
        complete_run;
    end
endmodule
bind adcr_regs adcr_regs_props adcr_regs_props_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_rd_en_in(reg_rd_en_in),
    .antenna_driver_one_on_in(antenna_driver_one_on_in),
    .antenna_driver_two_on_in(antenna_driver_two_on_in),
    .modulation_active_in(modulation_active_in),
    .forced_full_ask_in(forced_full_ask_in),
    .soft_power_down_in(soft_power_down_in),
    .reg_rdata_out(reg_rdata_out), .drive_out(drive_out),
    .reg_rdata_valid_out(reg_rdata_valid_out),
    .driver_active_out(driver_active_out));
`default_nettype wire
